// ---- inc/scg_pkg.sv ----
/*
  Constants, types and register map of the sample clock generator.
  Assumes a 250 MHz system clock and a 32-bit AXI4-Lite register port.
*/
`default_nettype none
package scg_pkg;
  // System clock and its period
  localparam logic [31:0] MCLK_HZ      = 32'h0EE6_B280;  // 250 MHz
  localparam logic [31:0] MCLK_NS      = 32'h0000_0004;  // 4 ns
  // Register indices; byte address is four times the index
  localparam int          ADDR_W       = 18;
  localparam logic [15:0] IDX_RATE     = 16'h4E20;  // sample_rate_request
  localparam logic [15:0] IDX_PLL      = 16'h4E3E;  // pll_path_select
  localparam logic [15:0] IDX_EXTDIV   = 16'h4E48;  // external clock divider
  localparam logic [15:0] IDX_EXTSRC   = 16'h4E84;  // external_clock_source_enable
  localparam logic [15:0] IDX_CLKOUT   = 16'h4E8E;  // clock_output_enable
  localparam logic [15:0] IDX_TERM     = 16'h4E98;  // clock_input_termination
  localparam logic [15:0] IDX_REF      = 16'h4EAC;  // pll_reference_select
  localparam logic [15:0] IDX_ACQ      = 16'h0100;  // acquisition run control
  localparam logic [15:0] IDX_STATUS   = 16'h0101;  // clock status
  // Rate limits and references
  localparam logic [31:0] MIN_HZ       = 32'h0000_03E8;  // 1 kHz
  localparam logic [31:0] MAX_HZ_LOW   = 32'h0001_86A0;  // 100 kS/s model
  localparam logic [31:0] MAX_HZ_MID   = 32'h0003_D090;  // 250 kS/s model
  localparam logic [31:0] MAX_HZ_TOP   = 32'h0007_A120;  // 500 kS/s model
  localparam logic [31:0] INT_REF_HZ   = 32'h0262_5A00;  // 40 MHz on-board
  localparam logic [31:0] BPL_REF_HZ   = 32'h0098_9680;  // 10 MHz backplane
  localparam logic [31:0] EXT_REF_MIN  = 32'h000F_4240;  // 1 MHz
  localparam logic [31:0] EXT_REF_MAX  = 32'h0773_5940;  // 125 MHz
  localparam logic [31:0] REF_BPL_CODE = 32'hFFFF_FFFF;  // value -1
  localparam logic [31:0] REF_INT_CODE = 32'h0000_0000;
  // Reset values
  localparam logic [31:0] RATE_RESET   = 32'h0001_86A0;
  localparam logic        PLL_RESET    = 1'b1;
  localparam logic [31:0] EXTDIV_RESET = 32'h0000_0001;
  // Status bit positions
  localparam int          ST_RUN_BIT   = 0;
  localparam int          ST_EXT_BIT   = 1;
  localparam int          ST_PLL_BIT   = 2;
  localparam int          ST_BAD_BIT   = 3;
  localparam int          ST_REF_LSB   = 4;
  // Quartz divider set
  localparam int          NUM_DIV      = 17;
  localparam logic [31:0] QDIV [NUM_DIV] = '{
    32'h0000_0001, 32'h0000_0002, 32'h0000_0004, 32'h0000_0008, 32'h0000_000A,
    32'h0000_0010, 32'h0000_0014, 32'h0000_0028, 32'h0000_0032, 32'h0000_0050,
    32'h0000_0064, 32'h0000_00C8, 32'h0000_0190, 32'h0000_01F4, 32'h0000_0320,
    32'h0000_03E8, 32'h0000_07D0};
  // AXI responses
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

  typedef enum logic [1:0] {
    REF_INTERNAL  = 2'b00,
    REF_EXTERNAL  = 2'b01,
    REF_BACKPLANE = 2'b10
  } scg_ref_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } scg_state_t;

  // Clock setup as one unit, pending or frozen for a run
  typedef struct packed {
    logic [31:0] rate;
    logic        pll_on;
    logic        ext_on;
    logic [31:0] ext_div;
    scg_ref_t    ref_sel;
    logic [31:0] ref_hz;
  } scg_cfg_t;
endpackage : scg_pkg
`default_nettype wire

// ---- hw/scg_sample_clock.sv ----
/*
  Sample clock generator: register file on AXI4-Lite, rate resolution for
  the PLL and quartz paths, reference selection, external clock divider and
  connector control. Assumes all inputs are synchronous to mclk; the
  connector pin is resolved by the surrounding logic from its enable.
*/
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Default source is PLL plus dividers fed by the 40 MHz on-board reference.
// - Software writes requested rate in hertz; it sets up clock generation.
// - Reading the rate returns the nearest achievable rate, not the raw request.
// - Clock output drives the connector only when enabled under internal clocking.
// - Internal rate never goes below 1 kHz.
// - Upper rate bound is one of three per-model maxima.
// - PLL control 1 (default) selects PLL path, 0 selects quartz divider.
// - Without PLL, rate is quartz divided by one of seventeen fixed dividers.
// - Quartz runs at the model maximum so divider one gives top rate.
// - Quartz mode still picks and reports the closest achievable rate.
// - Reference 0 is internal, -1 is backplane; other values give exact external hertz, 1-125 MHz.
// - External reference routes the connector clock into the PLL.
// - PLL multiplier and divider derive from reference and requested rate.
// - 50 ohm load only while connector is an input; else high impedance.
// - Backplane reference can feed the PLL.
// - External clock can be divided down into a slower sample clock.
// - External source enable 1 takes connector as sample clock; 0 internal.
// - Reference value minus one selects the backplane 10 MHz reference.
module scg_sample_clock
  import scg_pkg::*;
#(
  parameter logic [31:0] VARIANT_MAX_HZ = MAX_HZ_LOW  // Model maximum rate
) (
  input  wire logic              mclk,           // System clock
  input  wire logic              rst_n,          // Synchronous reset
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,   // Write address
  input  wire logic              s_axi_awvalid,  // Write address valid
  output logic                   s_axi_awready,  // Write address ready
  input  wire logic [31:0]       s_axi_wdata,    // Write data
  input  wire logic [3:0]        s_axi_wstrb,    // Write byte lanes
  input  wire logic              s_axi_wvalid,   // Write data valid
  output logic                   s_axi_wready,   // Write data ready
  output logic [1:0]             s_axi_bresp,    // Write response
  output logic                   s_axi_bvalid,   // Write response valid
  input  wire logic              s_axi_bready,   // Write response ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr,   // Read address
  input  wire logic              s_axi_arvalid,  // Read address valid
  output logic                   s_axi_arready,  // Read address ready
  output logic [31:0]            s_axi_rdata,    // Read data
  output logic [1:0]             s_axi_rresp,    // Read response
  output logic                   s_axi_rvalid,   // Read data valid
  input  wire logic              s_axi_rready,   // Read data ready
  input  wire logic              clk_conn_in,    // Connector level in
  output logic                   clk_conn_out,   // Connector level out
  output logic                   clk_conn_oe,    // Connector driven
  output logic                   term_load_en,   // 50 ohm load switch
  output logic [1:0]             pll_ref_route,  // PLL reference mux
  output logic                   pll_path_on,    // PLL path in use
  output logic [31:0]            pll_mult,       // PLL multiplier
  output logic [31:0]            pll_div,        // PLL divider
  output logic                   sample_clk,     // Sample clock
  output logic                   sample_tick     // One pulse per sample
);

  // Software-visible settings
  logic [31:0] rate_req;
  logic        pll_sel;
  logic [31:0] ext_div;
  logic        ext_src;
  logic        clk_out_en;
  logic        term_sel;
  logic [31:0] ref_val;
  logic        acq_run;

  // Pending and frozen setup, and run state
  scg_cfg_t    pend_cfg;
  scg_cfg_t    act_cfg;
  scg_state_t  state;

  // Rate resolution
  logic [31:0] clamp_rate;
  logic [31:0] qz_rate [NUM_DIV];
  logic [31:0] qz_dist [NUM_DIV];
  logic [31:0] qz_best;
  logic [31:0] achieved;
  logic        ref_bad;
  logic [31:0] status;

  // Bus slave state
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              wr_go;
  logic              wr_hit;
  logic [31:0]       rd_word;
  logic              rd_hit;

  // Generators
  logic [31:0] acc;
  logic [31:0] next_acc;
  logic        conn_prev;
  logic [31:0] ext_cnt;

  // Merge written byte lanes into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction : merge

  // Request clamped into the model band before either path resolves it
  always_comb begin
    if (rate_req < MIN_HZ) begin
      clamp_rate = MIN_HZ;
    end else if (rate_req > VARIANT_MAX_HZ) begin
      clamp_rate = VARIANT_MAX_HZ;
    end else begin
      clamp_rate = rate_req;
    end
  end

  // Quartz at model maximum; one candidate per divider
  for (genvar i = 0; i < NUM_DIV; i++) begin : g_qz
    assign qz_rate[i] = VARIANT_MAX_HZ / QDIV[i];
    assign qz_dist[i] = (qz_rate[i] < MIN_HZ) ? 32'hFFFF_FFFF :
                        (qz_rate[i] > clamp_rate) ? qz_rate[i] - clamp_rate :
                        clamp_rate - qz_rate[i];
  end

  // Closest quartz rate; ties keep the faster rate
  always_comb begin
    logic [31:0] best_d;
    best_d  = 32'hFFFF_FFFF;
    qz_best = qz_rate[0];
    for (int i = 0; i < NUM_DIV; i++) begin
      if (qz_dist[i] < best_d) begin
        best_d  = qz_dist[i];
        qz_best = qz_rate[i];
      end
    end
  end

  // PLL resolves every integer rate in band, so it reports the clamped value
  assign achieved = pll_sel ? clamp_rate : qz_best;
  assign ref_bad  = (ref_val != REF_INT_CODE) && (ref_val != REF_BPL_CODE) &&
                    ((ref_val < EXT_REF_MIN) || (ref_val > EXT_REF_MAX));

  // Pending setup built from the registers
  always_comb begin
    pend_cfg         = '0;
    pend_cfg.rate    = achieved;
    pend_cfg.pll_on  = pll_sel;
    pend_cfg.ext_on  = ext_src;
    pend_cfg.ext_div = (ext_div == 32'h0000_0000) ? EXTDIV_RESET : ext_div;
    if (ref_val == REF_INT_CODE) begin
      pend_cfg.ref_sel = REF_INTERNAL;
      pend_cfg.ref_hz  = INT_REF_HZ;
    end else if (ref_val == REF_BPL_CODE) begin
      pend_cfg.ref_sel = REF_BACKPLANE;
      pend_cfg.ref_hz  = BPL_REF_HZ;
    end else begin
      pend_cfg.ref_sel = REF_EXTERNAL;
      pend_cfg.ref_hz  = ref_val;
    end
  end

  // Run state; the setup is frozen at the start and held through the run
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state   <= ST_IDLE;
      act_cfg <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (acq_run) begin
            state   <= ST_RUN;
            act_cfg <= pend_cfg;
          end
        end
        ST_RUN: begin
          if (!acq_run) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // PLL programming words follow the frozen reference and rate
  assign pll_ref_route = act_cfg.ref_sel;
  assign pll_path_on   = act_cfg.pll_on;
  assign pll_mult      = act_cfg.rate;
  assign pll_div       = act_cfg.ref_hz;

  // Write channel: address and data taken in either order, one at a time
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_go         = aw_held && w_held && !s_axi_bvalid;
  assign wr_hit = (aw_addr[ADDR_W-1:2] == IDX_RATE) || (aw_addr[ADDR_W-1:2] == IDX_PLL) ||
                  (aw_addr[ADDR_W-1:2] == IDX_EXTDIV) || (aw_addr[ADDR_W-1:2] == IDX_EXTSRC) ||
                  (aw_addr[ADDR_W-1:2] == IDX_CLKOUT) || (aw_addr[ADDR_W-1:2] == IDX_TERM) ||
                  (aw_addr[ADDR_W-1:2] == IDX_REF) || (aw_addr[ADDR_W-1:2] == IDX_ACQ) ||
                  (aw_addr[ADDR_W-1:2] == IDX_STATUS);

  // Capture address and data, then answer
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= '0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register writes; status is read only and silently keeps its value
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rate_req   <= RATE_RESET;
      pll_sel    <= PLL_RESET;
      ext_div    <= EXTDIV_RESET;
      ext_src    <= 1'b0;
      clk_out_en <= 1'b0;
      term_sel   <= 1'b0;
      ref_val    <= REF_INT_CODE;
      acq_run    <= 1'b0;
    end else if (wr_go) begin
      if (aw_addr[ADDR_W-1:2] == IDX_RATE) begin
        rate_req <= merge(rate_req, w_data, w_strb);
      end else if (aw_addr[ADDR_W-1:2] == IDX_PLL) begin
        pll_sel <= w_strb[0] ? w_data[0] : pll_sel;
      end else if (aw_addr[ADDR_W-1:2] == IDX_EXTDIV) begin
        ext_div <= merge(ext_div, w_data, w_strb);
      end else if (aw_addr[ADDR_W-1:2] == IDX_EXTSRC) begin
        ext_src <= w_strb[0] ? w_data[0] : ext_src;
      end else if (aw_addr[ADDR_W-1:2] == IDX_CLKOUT) begin
        clk_out_en <= w_strb[0] ? w_data[0] : clk_out_en;
      end else if (aw_addr[ADDR_W-1:2] == IDX_TERM) begin
        term_sel <= w_strb[0] ? w_data[0] : term_sel;
      end else if (aw_addr[ADDR_W-1:2] == IDX_REF) begin
        ref_val <= merge(ref_val, w_data, w_strb);
      end else if (aw_addr[ADDR_W-1:2] == IDX_ACQ) begin
        acq_run <= w_strb[0] ? w_data[0] : acq_run;
      end
    end
  end

  // Status shows the frozen setup, except the bad-reference bit, which follows the pending reference
  always_comb begin
    status = 32'h0000_0000;
    status[ST_RUN_BIT] = (state == ST_RUN);
    status[ST_EXT_BIT] = act_cfg.ext_on;
    status[ST_PLL_BIT] = act_cfg.pll_on;
    status[ST_BAD_BIT] = ref_bad;
    status[ST_REF_LSB +: 2] = act_cfg.ref_sel;
  end

  // Read decode
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (s_axi_araddr[ADDR_W-1:2] == IDX_RATE) begin
      rd_word = achieved;
    end else if (s_axi_araddr[ADDR_W-1:2] == IDX_PLL) begin
      rd_word[0] = pll_sel;
    end else if (s_axi_araddr[ADDR_W-1:2] == IDX_EXTDIV) begin
      rd_word = ext_div;
    end else if (s_axi_araddr[ADDR_W-1:2] == IDX_EXTSRC) begin
      rd_word[0] = ext_src;
    end else if (s_axi_araddr[ADDR_W-1:2] == IDX_CLKOUT) begin
      rd_word[0] = clk_out_en;
    end else if (s_axi_araddr[ADDR_W-1:2] == IDX_TERM) begin
      rd_word[0] = term_sel;
    end else if (s_axi_araddr[ADDR_W-1:2] == IDX_REF) begin
      rd_word = ref_val;
    end else if (s_axi_araddr[ADDR_W-1:2] == IDX_ACQ) begin
      rd_word[0] = acq_run;
    end else if (s_axi_araddr[ADDR_W-1:2] == IDX_STATUS) begin
      rd_word = status;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Read channel: one outstanding read, answered the cycle after it is taken
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Internal generator: phase accumulator at twice the rate gives a square wave
  assign next_acc = acc + {act_cfg.rate[30:0], 1'b0};
  always_ff @(posedge mclk) begin
    if (!rst_n || state != ST_RUN || act_cfg.ext_on) begin
      acc        <= 32'h0000_0000;
      sample_clk <= 1'b0;
    end else if (next_acc >= MCLK_HZ) begin
      acc        <= next_acc - MCLK_HZ;
      sample_clk <= !sample_clk;
    end else begin
      acc <= next_acc;
    end
  end

  // External divider counts connector rising edges
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      conn_prev <= 1'b0;
      ext_cnt   <= 32'h0000_0000;
    end else begin
      conn_prev <= clk_conn_in;
      if (state != ST_RUN || !act_cfg.ext_on) begin
        ext_cnt <= 32'h0000_0000;
      end else if (clk_conn_in && !conn_prev) begin
        ext_cnt <= (ext_cnt + 32'h0000_0001 >= act_cfg.ext_div) ? 32'h0000_0000 :
                   ext_cnt + 32'h0000_0001;
      end
    end
  end

  // Sample strobe: internal rising edge, or each divided external edge
  always_ff @(posedge mclk) begin
    if (!rst_n || state != ST_RUN) begin
      sample_tick <= 1'b0;
    end else if (act_cfg.ext_on) begin
      sample_tick <= clk_conn_in && !conn_prev &&
                     (ext_cnt + 32'h0000_0001 >= act_cfg.ext_div);
    end else begin
      sample_tick <= !sample_clk && (next_acc >= MCLK_HZ);
    end
  end

  // Connector: drive only under internal clocking; the load only as an input
  assign clk_conn_oe  = clk_out_en && !act_cfg.ext_on;
  assign clk_conn_out = clk_conn_oe && sample_clk;
  assign term_load_en = term_sel && !clk_conn_oe;

  // Checks
  sequence s_write_taken;
    wr_go;
  endsequence
  sequence s_start;
    state == ST_IDLE && acq_run;
  endsequence

  a_term_input_only: assert property (@(posedge mclk) disable iff (!rst_n)
    term_load_en |-> !clk_conn_oe && term_sel) else $error("Load on while driving");
  a_clkout_internal: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_conn_oe |-> clk_out_en && !act_cfg.ext_on) else $error("Clock out misdriven");
  a_rate_band: assert property (@(posedge mclk) disable iff (!rst_n)
    achieved >= MIN_HZ) else $error("Rate below floor");
  a_rate_ceiling: assert property (@(posedge mclk) disable iff (!rst_n)
    achieved <= VARIANT_MAX_HZ) else $error("Rate above model maximum");
  a_pll_readback: assert property (@(posedge mclk) disable iff (!rst_n)
    pll_sel && rate_req >= MIN_HZ && rate_req <= VARIANT_MAX_HZ |-> achieved == rate_req)
    else $error("PLL readback differs");
  a_start_snapshot: assert property (@(posedge mclk) disable iff (!rst_n)
    s_start |=> state == ST_RUN && act_cfg.rate == $past(achieved) &&
    act_cfg.ext_on == $past(ext_src)) else $error("Setup not frozen at start");
  a_run_frozen: assert property (@(posedge mclk) disable iff (!rst_n)
    state == ST_RUN && $past(state) == ST_RUN |-> $stable(act_cfg))
    else $error("Setup changed during run");
  a_ref_backplane: assert property (@(posedge mclk) disable iff (!rst_n)
    state == ST_IDLE && acq_run && ref_val == REF_BPL_CODE
    |=> pll_ref_route == REF_BACKPLANE && pll_div == BPL_REF_HZ)
    else $error("Backplane reference not routed");
  a_ext_no_internal: assert property (@(posedge mclk) disable iff (!rst_n)
    state == ST_RUN && act_cfg.ext_on |=> !sample_clk && !clk_conn_oe)
    else $error("Internal clock under external source");
  a_write_answer: assert property (@(posedge mclk) disable iff (!rst_n)
    s_write_taken |=> s_axi_bvalid [*1] ##0 !s_axi_awready) else $error("No write answer");

endmodule : scg_sample_clock
`default_nettype wire

// ---- test/scg_conn_osc.sv ----
/*
  Model of the equipment on the clock connector: a reference oscillator.
  Assumes it is clocked by mclk and that the bench resolves the pin level.
*/
`timescale 1ns/1ns
`default_nettype none
module scg_conn_osc #(
  parameter int HALF = 10  // Half period in mclk cycles
) (
  input  wire logic mclk,     // Bench clock
  input  wire logic en,       // Oscillator powered
  input  wire logic conn_oe,  // Board drives the pin
  output logic      lvl       // Level offered to the pin
);
  int cnt;
  // Free toggle while powered; stands still at 0 when off or overdriven
  always_ff @(posedge mclk) begin
    if (!en || conn_oe) begin
      cnt <= 0;
      lvl <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      lvl <= !lvl;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : scg_conn_osc
`default_nettype wire

// ---- test/scg_sample_clock_tb_top.sv ----
/*
  Bench of the sample clock generator: AXI4-Lite tasks and register tests.
  Assumes the design with its default model maximum of 100 kS/s.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module scg_sample_clock_tb_top;
  import scg_pkg::*;
  logic mclk, rst_n, awv, wv, bv, br, arv, rv, rr, awr, wr_r, arr, osc_en, osc, cout, coe;
  logic term, pon, sclk, tick;
  logic [17:0] awa, ara;
  logic [31:0] wd, rd, mult, div;
  logic [3:0]  ws;
  logic [1:0]  bresp, rresp, route, r;
  logic [31:0] v;
  int          n_fail, tests_run, ticks, t0, c0, crise;
  logic        cprev;
  logic [31:0] exp_st;
  wire         cin = coe ? cout : osc;  // Pin level from both parties
  scg_sample_clock dut (.mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .clk_conn_in(cin),
    .clk_conn_out(cout), .clk_conn_oe(coe), .term_load_en(term), .pll_ref_route(route),
    .pll_path_on(pon), .pll_mult(mult), .pll_div(div), .sample_clk(sclk),
    .sample_tick(tick));
  scg_conn_osc osc_m (.mclk(mclk), .en(osc_en), .conn_oe(coe), .lvl(osc));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = !mclk;
  end
  always @(posedge mclk) ticks <= ticks + int'(tick);
  // Rising edges seen on the connector pin, whoever drives it
  always @(posedge mclk) begin
    cprev <= cin;
    crise <= crise + int'(cin && !cprev);
  end
  task automatic test_done;
    if (n_fail == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [15:0] i, input logic [31:0] d, input logic [1:0] er);
    @(posedge mclk);
    awa <= {i, 2'b00}; wd <= d; ws <= 4'hF; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    for (int k = 0; k <= 200; k++) begin
      @(posedge mclk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_r) wv <= 1'b0;
      if (bv) begin
        br <= 1'b0;
        `CHK(bresp, er)
        break;
      end
      if (k == 200) begin n_fail++; test_done(); end
    end
  endtask : wr
  task automatic rdr(input logic [15:0] i, output logic [31:0] d, output logic [1:0] e);
    @(posedge mclk);
    ara <= {i, 2'b00}; arv <= 1'b1; rr <= 1'b1;
    for (int k = 0; k <= 200; k++) begin
      @(posedge mclk);
      if (arv && arr) arv <= 1'b0;
      if (rv) begin d = rd; e = rresp; rr <= 1'b0; break; end
      if (k == 200) begin n_fail++; test_done(); end
    end
  endtask : rdr
  // Request a rate and compare the readback
  task automatic rate(input logic [31:0] req, input logic [31:0] exp);
    wr(IDX_RATE, req, RESP_OKAY);
    rdr(IDX_RATE, v, r);
    `CHK(v, exp)
  endtask : rate
  // Restart so that pending settings are frozen
  task automatic restart;
    wr(IDX_ACQ, 32'h0000_0000, RESP_OKAY);
    wr(IDX_ACQ, 32'h0000_0001, RESP_OKAY);
    repeat (4) @(posedge mclk);
  endtask : restart
  initial begin
    {awv, wv, br, arv, rr, osc_en} = '0;
    awa = '0; ara = '0; wd = '0; ws = '0; ticks = 0; rst_n = 1'b0;
    crise = 0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    rdr(IDX_RATE, v, r);
    `CHK(v, RATE_RESET)
    rdr(IDX_PLL, v, r);
    `CHK(v[0], PLL_RESET)
    rdr(16'h0200, v, r);
    `CHK(r, RESP_SLVERR)
    wr(16'h0200, 32'h0000_0001, RESP_SLVERR);
    rate(32'h0000_01F4, MIN_HZ);
    rate(32'h0003_0D40, MAX_HZ_LOW);
    rate(32'h0000_3039, 32'h0000_3039);
    wr(IDX_PLL, 32'h0000_0000, RESP_OKAY);
    rate(32'h0000_7530, 32'h0000_61A8);
    rate(32'h0001_86A0, MAX_HZ_LOW);
    rate(32'h0000_0064, MIN_HZ);
    restart();
    `CHK(pon, 1'b0)
    wr(IDX_PLL, 32'h0000_0001, RESP_OKAY);
    wr(IDX_CLKOUT, 32'h0000_0001, RESP_OKAY);
    wr(IDX_TERM, 32'h0000_0001, RESP_OKAY);
    rate(32'h0001_86A0, MAX_HZ_LOW);
    restart();
    `CHK({pon, route, mult, div}, {1'b1, REF_INTERNAL, MAX_HZ_LOW, INT_REF_HZ})
    `CHK({coe, term}, 2'b10)
    // Snapshots, not a clear: a clear would race the counting process
    t0 = ticks;
    c0 = crise;
    repeat (10000) @(posedge mclk);
    `CHK((ticks - t0) inside {[3:5]}, 1'b1)
    `CHK((crise - c0) inside {[3:5]}, 1'b1)
    wr(IDX_RATE, 32'h0000_4E20, RESP_OKAY);
    `CHK(mult, MAX_HZ_LOW)
    wr(IDX_CLKOUT, 32'h0000_0000, RESP_OKAY);
    wr(IDX_REF, REF_BPL_CODE, RESP_OKAY);
    restart();
    `CHK({route, div, term}, {REF_BACKPLANE, BPL_REF_HZ, 1'b1})
    osc_en <= 1'b1;
    wr(IDX_REF, 32'h0098_9680, RESP_OKAY);
    restart();
    `CHK({route, div}, {REF_EXTERNAL, 32'h0098_9680})
    wr(IDX_CLKOUT, 32'h0000_0001, RESP_OKAY);
    wr(IDX_EXTSRC, 32'h0000_0001, RESP_OKAY);
    wr(IDX_EXTDIV, 32'h0000_0002, RESP_OKAY);
    restart();
    `CHK(coe, 1'b0)
    t0 = ticks;
    repeat (400) @(posedge mclk);
    `CHK((ticks - t0) inside {[9:11]}, 1'b1)
    `CHK(sclk, 1'b0)
    // Status shows the frozen external setup on the PLL path
    exp_st = (32'h1 << ST_RUN_BIT) | (32'h1 << ST_EXT_BIT) | (32'h1 << ST_PLL_BIT);
    exp_st[ST_REF_LSB +: 2] = REF_EXTERNAL;
    rdr(IDX_STATUS, v, r);
    `CHK(v, exp_st)
    // Out-of-band reference is flagged but not applied during the run
    wr(IDX_REF, 32'h0000_0010, RESP_OKAY);
    rdr(IDX_STATUS, v, r);
    `CHK(v[ST_BAD_BIT], 1'b1)
    `CHK(div, 32'h0098_9680)
    test_done();
  end
  initial begin
    #200000;
    n_fail++;
    test_done();
  end
endmodule : scg_sample_clock_tb_top
`default_nettype wire
